// [inc/cell_monitor_pkg.sv]
// Shared constants, commands and register map for the cell monitor link.
package cell_monitor_pkg;

	localparam int NCELL = 12;
	localparam int NCHAN = 15;
	localparam logic [3:0] CH_CELL_FIRST = 4'h0;
	localparam logic [3:0] CH_CELL_LAST = 4'hb;
	localparam logic [3:0] CH_CELL_LAST_TEN = 4'h9;
	localparam logic [3:0] CH_TEMP_FIRST = 4'hc;
	localparam logic [3:0] CH_TEMP_LAST = 4'he;
	localparam logic [3:0] CH_TEMP_FLAG = 4'hf;

	// Configuration word carried by the configuration write command.
	localparam int CFG_DIS_LSB = 0;
	localparam int CFG_CDC_LSB = 12;
	localparam int CFG_TEN_BIT = 15;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	localparam logic [11:0] SELF1_PATTERN = 12'h555;
	localparam logic [11:0] SELF2_PATTERN = 12'haaa;

	// Comparison rounds: interval between rounds and length of one round.
	localparam logic [15:0] COMPARE_PERIOD_CYCLES = 16'h03e8;
	localparam logic [7:0] COMPARE_LEN_CYCLES = 8'h10;

	// Open-wire threshold in converter codes.
	localparam logic [12:0] OPEN_THRESH_CODE = 13'h0085;

	typedef enum logic [3:0] {
		cmd_nop = 4'h0,
		cmd_write_cfg = 4'h1,
		start_cell_conv_plain = 4'h2,
		start_cell_conv_openwire = 4'h3,
		start_cell_conv_keep_discharge = 4'h4,
		start_openwire_conv_keep_discharge = 4'h5,
		start_temp_conv = 4'h6,
		self_test1_cells = 4'h7,
		self_test2_cells = 4'h8,
		self_test1_temps = 4'h9,
		self_test2_temps = 4'ha,
		read_cell_voltage_group = 4'hb,
		read_temperature_group = 4'hc
	} cmd_t;

	// APB register map of the controller.
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_CFG = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [11:0] REG_OW_REPEAT = 12'h00c;
	localparam logic [11:0] REG_OPEN = 12'h010;
	localparam logic [11:0] REG_READING = 12'h040;
	localparam int CTRL_OW_BIT = 8;
	localparam logic [3:0] OW_REPEAT_RESET = 4'h1;

endpackage : cell_monitor_pkg

// [inc/cell_link_if.sv]
// Command and response link between controller and monitor sequencer.
`timescale 1ns/100ps
`default_nettype none
interface cell_link_if;
	logic cmd_valid;
	logic cmd_ready;
	logic [3:0] cmd_code;
	logic [3:0] cmd_cell;
	logic [15:0] cmd_data;
	logic busy;
	logic rsp_valid;
	logic rsp_last;
	logic [15:0] rsp_data;

	modport dev (input cmd_valid, cmd_code, cmd_cell, cmd_data,
		output cmd_ready, busy, rsp_valid, rsp_last, rsp_data);
	modport host (output cmd_valid, cmd_code, cmd_cell, cmd_data,
		input cmd_ready, busy, rsp_valid, rsp_last, rsp_data);
endinterface : cell_link_if
`default_nettype wire

// [core/interval_timer.sv]
// Interval divider, cleared while enable is low, that emits a one-cycle tick.
`timescale 1ns/100ps
`default_nettype none
module interval_timer
	import cell_monitor_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	output logic tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} tmr_state_t;

	tmr_state_t r_reg;
	tmr_state_t r_next;

	always_comb begin
		r_next = r_reg;
		r_next.tick = 1'b0;
		if (!enable) begin
			r_next.cnt = 16'h0000;
		end else if (r_reg.cnt == COMPARE_PERIOD_CYCLES - 16'h0001) begin
			r_next.cnt = 16'h0000;
			r_next.tick = 1'b1;
		end else begin
			r_next.cnt = r_reg.cnt + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign tick = r_reg.tick;
endmodule : interval_timer
`default_nettype wire

// [core/monitor_sequencer.sv]
// Monitor end: conversion sequencer, discharge gating and thermal response.
`timescale 1ns/100ps
`default_nettype none
module monitor_sequencer
	import cell_monitor_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	cell_link_if.dev link,
	input wire logic adc_done,
	input wire logic [11:0] adc_data,
	input wire logic overtemp,
	output logic adc_start,
	output logic [3:0] mux_sel,
	output logic test_source_en,
	output logic [1:0] test_inject,
	output logic [NCELL-1:0] discharge_sw,
	output logic compare_active
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CONV_SET = 3'b001,
		S_CONV_WAIT = 3'b010,
		S_READ = 3'b011,
		S_COMPARE = 3'b100
	} seq_state_t;

	typedef struct packed {
		seq_state_t st;
		logic [15:0] cfg;
		logic thermal_shutdown_flag;
		logic [3:0] ch;
		logic [3:0] last;
		logic gate_on;
		logic ow_on;
		logic [1:0] test;
		logic [NCHAN-1:0][11:0] res;
		logic [7:0] cnt;
		logic done_s1;
		logic done_s2;
		logic done_s3;
		logic [11:0] data_s1;
		logic [11:0] data_s2;
		logic ot_s1;
		logic ot_s2;
		logic cmd_ready;
		logic busy;
		logic rsp_valid;
		logic rsp_last;
		logic [15:0] rsp_data;
		logic adc_start;
		logic [3:0] mux_sel;
		logic test_source_en;
		logic [1:0] test_inject;
		logic [NCELL-1:0] discharge_sw;
		logic compare_active;
	} seq_t;

	seq_t r_reg;
	seq_t r_next;
	logic tick;

	// Cells c-1, c and c+1 of the one under conversion.
	function automatic logic [NCELL-1:0] gate_mask(input logic [3:0] c);
		logic [13:0] m;
		m = 14'h0007 << c;
		return m[12:1];
	endfunction : gate_mask

	function automatic logic [3:0] cell_last(input logic [15:0] cfg);
		return cfg[CFG_TEN_BIT] ? CH_CELL_LAST_TEN : CH_CELL_LAST;
	endfunction : cell_last

	interval_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.enable(r_reg.st == S_IDLE && r_reg.cfg[CFG_CDC_LSB+:3] != 3'h0),
		.tick(tick)
	);

	always_comb begin
		r_next = r_reg;
		r_next.adc_start = 1'b0;
		r_next.rsp_valid = 1'b0;
		r_next.rsp_last = 1'b0;
		r_next.done_s1 = adc_done;
		r_next.done_s2 = r_reg.done_s1;
		r_next.done_s3 = r_reg.done_s2;
		r_next.data_s1 = adc_data;
		r_next.data_s2 = r_reg.data_s1;
		r_next.ot_s1 = overtemp;
		r_next.ot_s2 = r_reg.ot_s1;
		case (r_reg.st)
		S_IDLE: begin
			if (link.cmd_valid && r_reg.cmd_ready) begin
				r_next.gate_on = 1'b0;
				r_next.ow_on = 1'b0;
				r_next.test = 2'h0;
				r_next.ch = CH_CELL_FIRST;
				r_next.last = cell_last(r_reg.cfg);
				case (link.cmd_code)
				cmd_write_cfg: begin
					r_next.cfg = link.cmd_data;
				end
				start_cell_conv_plain,
				start_cell_conv_openwire,
				start_cell_conv_keep_discharge,
				start_openwire_conv_keep_discharge: begin
					r_next.gate_on = link.cmd_code == start_cell_conv_plain ||
						link.cmd_code == start_cell_conv_openwire;
					r_next.ow_on = link.cmd_code == start_cell_conv_openwire ||
						link.cmd_code == start_openwire_conv_keep_discharge;
					if (link.cmd_cell != 4'h0) begin
						r_next.ch = link.cmd_cell - 4'h1;
						r_next.last = link.cmd_cell - 4'h1;
					end
					// Out-of-range cells and standby both leave it idle.
					if (link.cmd_cell <= 4'hc &&
						r_reg.cfg[CFG_CDC_LSB+:3] != 3'h0) begin
						r_next.st = S_CONV_SET;
					end
				end
				start_temp_conv, self_test1_cells, self_test2_cells,
				self_test1_temps, self_test2_temps: begin
					if (link.cmd_code == self_test1_cells ||
						link.cmd_code == self_test1_temps) begin
						r_next.test = 2'h1;
					end else if (link.cmd_code != start_temp_conv) begin
						r_next.test = 2'h2;
					end
					if (link.cmd_code != self_test1_cells &&
						link.cmd_code != self_test2_cells) begin
						r_next.ch = CH_TEMP_FIRST;
						r_next.last = CH_TEMP_LAST;
					end
					if (r_reg.cfg[CFG_CDC_LSB+:3] != 3'h0) begin
						r_next.st = S_CONV_SET;
					end
				end
				read_cell_voltage_group: begin
					r_next.st = S_READ;
				end
				read_temperature_group: begin
					r_next.ch = CH_TEMP_FIRST;
					r_next.last = CH_TEMP_FLAG;
					r_next.st = S_READ;
				end
				default: begin
				end
				endcase
			end else if (tick) begin
				r_next.cnt = 8'h00;
				r_next.st = S_COMPARE;
			end
		end
		S_CONV_SET: begin
			r_next.adc_start = 1'b1;
			r_next.st = S_CONV_WAIT;
		end
		S_CONV_WAIT: begin
			if (r_reg.done_s2 && !r_reg.done_s3) begin
				// The pattern is taken where the injected word leaves the filter.
				case (r_reg.test)
				2'h1: r_next.res[r_reg.ch] = SELF1_PATTERN;
				2'h2: r_next.res[r_reg.ch] = SELF2_PATTERN;
				default: r_next.res[r_reg.ch] = r_reg.data_s2;
				endcase
				if (r_reg.ch == r_reg.last) begin
					r_next.st = S_IDLE;
				end else begin
					r_next.ch = r_reg.ch + 4'h1;
					r_next.st = S_CONV_SET;
				end
			end
		end
		S_READ: begin
			r_next.rsp_valid = 1'b1;
			if (r_reg.ch == CH_TEMP_FLAG) begin
				r_next.rsp_data = {15'h0000, r_reg.thermal_shutdown_flag};
				r_next.thermal_shutdown_flag = 1'b0;
			end else begin
				r_next.rsp_data = {4'h0, r_reg.res[r_reg.ch]};
			end
			if (r_reg.ch == r_reg.last) begin
				r_next.rsp_last = 1'b1;
				r_next.st = S_IDLE;
			end else begin
				r_next.ch = r_reg.ch + 4'h1;
			end
		end
		S_COMPARE: begin
			r_next.cnt = r_reg.cnt + 8'h01;
			if (r_reg.cnt == COMPARE_LEN_CYCLES - 8'h01) begin
				r_next.st = S_IDLE;
			end
		end
		default: begin
			r_next.st = S_IDLE;
		end
		endcase
		if (r_reg.ot_s2) begin
			r_next.cfg = CFG_RESET;
			r_next.thermal_shutdown_flag = 1'b1;
			if (r_next.st != S_READ) begin
				r_next.st = S_IDLE;
			end
		end
		// Writing standby mid-conversion abandons the remaining channels.
		if (r_next.cfg[CFG_CDC_LSB+:3] == 3'h0 &&
			(r_next.st == S_CONV_SET || r_next.st == S_CONV_WAIT)) begin
			r_next.st = S_IDLE;
		end
		r_next.mux_sel = r_next.ch;
		r_next.test_inject = 2'h0;
		r_next.test_source_en = 1'b0;
		r_next.compare_active = r_next.st == S_COMPARE;
		r_next.discharge_sw = r_next.cfg[CFG_DIS_LSB+:NCELL];
		if (r_next.st == S_CONV_SET || r_next.st == S_CONV_WAIT) begin
			r_next.test_inject = r_next.test;
			r_next.test_source_en = r_next.ow_on &&
				r_next.ch <= CH_CELL_LAST;
			if (r_next.gate_on) begin
				r_next.discharge_sw = r_next.discharge_sw &
					~gate_mask(r_next.ch);
			end
		end else if (r_next.st == S_COMPARE) begin
			r_next.discharge_sw = '0;
		end
		r_next.busy = r_next.st != S_IDLE;
		r_next.cmd_ready = r_next.st == S_IDLE && !r_reg.ot_s2;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign link.cmd_ready = r_reg.cmd_ready;
	assign link.busy = r_reg.busy;
	assign link.rsp_valid = r_reg.rsp_valid;
	assign link.rsp_last = r_reg.rsp_last;
	assign link.rsp_data = r_reg.rsp_data;
	assign adc_start = r_reg.adc_start;
	assign mux_sel = r_reg.mux_sel;
	assign test_source_en = r_reg.test_source_en;
	assign test_inject = r_reg.test_inject;
	assign discharge_sw = r_reg.discharge_sw;
	assign compare_active = r_reg.compare_active;
endmodule : monitor_sequencer
`default_nettype wire

// [core/monitor_controller.sv]
// Controller end: APB registers, command issue and open-wire check.
`timescale 1ns/100ps
`default_nettype none
module monitor_controller
	import cell_monitor_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	cell_link_if.host link
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_ISSUE = 3'b001,
		H_WAIT = 3'b010,
		H_COLLECT = 3'b011,
		H_CHECK = 3'b100
	} host_state_t;

	typedef struct packed {
		host_state_t st;
		logic ow_run;
		logic [1:0] step;
		logic [3:0] rep;
		logic [3:0] rep_cnt;
		logic [15:0] cfg;
		logic [3:0] rd_i;
		logic [3:0] rd_n;
		logic count_err;
		logic flag_seen;
		logic [NCHAN-1:0][11:0] reading;
		logic [NCELL-1:0][11:0] baseline_readings;
		logic [10:0] open_mask;
		logic cmd_valid;
		logic [3:0] cmd_code;
		logic [3:0] cmd_cell;
		logic [15:0] cmd_data;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} host_t;

	host_t r_reg;
	host_t r_next;

	// Loaded minus baseline, at or above the open threshold.
	function automatic logic rise_ge(input logic [11:0] loaded,
		input logic [11:0] base);
		logic [12:0] d;
		d = {1'b0, loaded} - {1'b0, base};
		return !d[12] && d >= OPEN_THRESH_CODE;
	endfunction : rise_ge

	always_comb begin
		r_next = r_reg;
		r_next.pready = 1'b0;
		r_next.pslverr = 1'b0;
		if (psel && penable && !r_reg.pready) begin
			r_next.pready = 1'b1;
			r_next.prdata = 32'h00000000;
			if (paddr >= REG_READING &&
				paddr < REG_READING + 12'h03c && paddr[1:0] == 2'h0) begin
				r_next.prdata = {20'h00000,
					r_reg.reading[paddr[5:2] - REG_READING[5:2]]};
				r_next.pslverr = pwrite;
			end else begin
				case (paddr)
				REG_CTRL: begin
					if (pwrite && r_reg.st == H_IDLE) begin
						r_next.st = H_ISSUE;
						r_next.cmd_data = r_reg.cfg;
						r_next.ow_run = pwdata[CTRL_OW_BIT];
						r_next.step = 2'h0;
						r_next.rep_cnt = 4'h0;
						r_next.cmd_code = pwdata[CTRL_OW_BIT] ?
							start_cell_conv_plain : pwdata[3:0];
						r_next.cmd_cell = pwdata[CTRL_OW_BIT] ? 4'h0 :
							pwdata[7:4];
					end
					r_next.prdata = {24'h000000, r_reg.cmd_cell, r_reg.cmd_code};
				end
				REG_CFG: begin
					if (pwrite) begin
						r_next.cfg = pwdata[15:0];
					end
					r_next.prdata = {16'h0000, r_reg.cfg};
				end
				REG_STATUS: begin
					r_next.prdata = {28'h0000000, r_reg.count_err,
						r_reg.flag_seen, r_reg.ow_run, r_reg.st != H_IDLE};
				end
				REG_OW_REPEAT: begin
					if (pwrite) begin
						r_next.rep = pwdata[3:0];
					end
					r_next.prdata = {28'h0000000, r_reg.rep};
				end
				REG_OPEN: begin
					r_next.prdata = {20'h00000, 1'b0, r_reg.open_mask};
				end
				default: begin
					r_next.pslverr = 1'b1;
				end
				endcase
			end
		end
		case (r_reg.st)
		H_IDLE: begin
		end
		H_ISSUE: begin
			r_next.cmd_valid = 1'b1;
			if (r_reg.cmd_valid && link.cmd_ready) begin
				r_next.cmd_valid = 1'b0;
				r_next.rd_n = 4'h0;
				r_next.rd_i = r_reg.cmd_code == read_temperature_group ?
					CH_TEMP_FIRST : CH_CELL_FIRST;
				r_next.st = (r_reg.cmd_code == read_cell_voltage_group ||
					r_reg.cmd_code == read_temperature_group) ?
					H_COLLECT : H_WAIT;
			end
		end
		H_WAIT: begin
			if (!link.busy) begin
				r_next.st = H_IDLE;
				if (r_reg.ow_run) begin
					r_next.st = H_ISSUE;
					r_next.cmd_code = read_cell_voltage_group;
					r_next.rep_cnt = r_reg.rep_cnt + 4'h1;
					// Filter capacitors need several loaded passes to discharge.
					if (r_reg.step == 2'h2 &&
						r_reg.rep_cnt + 4'h1 < r_reg.rep) begin
						r_next.cmd_code = start_cell_conv_openwire;
					end
					r_next.step = r_reg.step + 2'h1;
					if (r_reg.step == 2'h2 && r_next.cmd_code !=
						read_cell_voltage_group) begin
						r_next.step = 2'h2;
					end
				end
			end
		end
		H_COLLECT: begin
			if (link.rsp_valid) begin
				if (r_reg.rd_i == CH_TEMP_FLAG) begin
					r_next.flag_seen = link.rsp_data[0];
				end else begin
					r_next.reading[r_reg.rd_i] = link.rsp_data[11:0];
				end
				r_next.rd_i = r_reg.rd_i + 4'h1;
				r_next.rd_n = r_reg.rd_n + 4'h1;
				if (link.rsp_last) begin
					r_next.st = H_IDLE;
					r_next.count_err = r_reg.cmd_code ==
						read_cell_voltage_group && r_reg.rd_n + 4'h1 !=
						(r_reg.cfg[CFG_TEN_BIT] ? 4'ha : 4'hc);
					if (r_reg.ow_run && r_reg.step == 2'h1) begin
						r_next.baseline_readings =
							r_next.reading[NCELL-1:0];
						r_next.st = H_ISSUE;
						r_next.step = 2'h2;
						r_next.rep_cnt = 4'h0;
						r_next.cmd_code = start_cell_conv_openwire;
					end else if (r_reg.ow_run) begin
						r_next.st = H_CHECK;
					end
				end
			end
		end
		H_CHECK: begin
			for (int n = 0; n < NCELL - 1; n++) begin
				r_next.open_mask[n] = rise_ge(r_reg.reading[n+1],
					r_reg.baseline_readings[n+1]);
			end
			r_next.ow_run = 1'b0;
			r_next.st = H_IDLE;
		end
		default: begin
			r_next.st = H_IDLE;
		end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
			r_reg.rep <= OW_REPEAT_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	assign pready = r_reg.pready;
	assign prdata = r_reg.prdata;
	assign pslverr = r_reg.pslverr;
	assign link.cmd_valid = r_reg.cmd_valid;
	assign link.cmd_code = r_reg.cmd_code;
	assign link.cmd_cell = r_reg.cmd_cell;
	assign link.cmd_data = r_reg.cmd_data;
endmodule : monitor_controller
`default_nettype wire

// [sim/cell_link_sva.sv]
// Link checker for the cell monitor command and response link.
`timescale 1ns/100ps
`default_nettype none
module cell_link_sva
	import cell_monitor_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [3:0] cmd_code,
	input wire logic [3:0] cmd_cell,
	input wire logic [15:0] cmd_data,
	input wire logic busy,
	input wire logic rsp_valid,
	input wire logic rsp_last,
	input wire logic [15:0] rsp_data
);
	logic take;
	logic conv;
	logic [15:0] cfg_reg;
	logic [3:0] last_reg;
	logic [1:0] kind_reg;
	logic [3:0] cnt_reg;
	assign take = cmd_valid && cmd_ready;
	assign conv = cmd_code >= 4'h2 && cmd_code <= 4'ha;
	// The copy of the configuration misses the overtemperature reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= CFG_RESET;
			last_reg <= 4'h0;
			kind_reg <= 2'h0;
			cnt_reg <= 4'h0;
		end else begin
			if (take && cmd_code == cmd_write_cfg)
				cfg_reg <= cmd_data;
			if (take && conv)
				last_reg <= cmd_code;
			if (take && cmd_code == read_cell_voltage_group)
				kind_reg <= 2'h1;
			if (take && cmd_code == read_temperature_group)
				kind_reg <= 2'h2;
			if (take)
				cnt_reg <= 4'h0;
			else if (rsp_valid)
				cnt_reg <= cnt_reg + 4'h1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	conv_start_busy_a: assert property (take && conv && cmd_cell <= 4'hc
		&& cfg_reg[14:12] != 3'h0 |=> busy) else $error("conversion not started");
	standby_refuse_a: assert property (take && conv && cfg_reg[14:12] == 3'h0
		|=> !busy ##1 !busy) else $error("conversion ran in standby");
	read_answer_a: assert property (take && cmd_code == read_cell_voltage_group
		|=> busy ##1 rsp_valid) else $error("read not answered");
	cell_count_a: assert property (rsp_last && kind_reg == 2'h1
		|-> cnt_reg == (cfg_reg[CFG_TEN_BIT] ? 4'h9 : 4'hb)) else $error("cell count");
	temp_count_a: assert property (rsp_last && kind_reg == 2'h2
		|-> cnt_reg == 4'h3 && rsp_valid) else $error("temperature count");
	self_one_a: assert property (rsp_valid && kind_reg == 2'h1 && last_reg == 4'h7
		|-> rsp_data[11:0] == SELF1_PATTERN) else $error("self test one");
	self_two_a: assert property (rsp_valid && kind_reg == 2'h1 && last_reg == 4'h8
		|-> rsp_data[11:0] == SELF2_PATTERN) else $error("self test two");
	temp_self_a: assert property (rsp_valid && !rsp_last && kind_reg == 2'h2
		&& (last_reg == 4'h9 || last_reg == 4'ha) |-> rsp_data[11:0] ==
		(last_reg == 4'h9 ? SELF1_PATTERN : SELF2_PATTERN)) else $error("temp self");
endmodule : cell_link_sva
`default_nettype wire

// [sim/cell_measure_discharge_control_test.sv]
// Testbench joining controller and sequencer, driven over APB.
`timescale 1ns/100ps
`default_nettype none
module cell_measure_discharge_control_test;
	import cell_monitor_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic adc_done, overtemp, adc_start, test_source_en, compare_active, er;
	logic chk, duty_on;
	logic [11:0] adc_data, discharge_sw, en;
	logic [12:0] gm;
	logic [3:0] mux_sel, lastm;
	logic [1:0] test_inject, einj, gate;
	logic esrc;
	int n_fail, total_checks, nst, wt, i, j;
	cell_link_if lk ();
	monitor_sequencer u_monitor_sequencer (.pclk(pclk), .presetn(presetn),
		.link(lk), .adc_done(adc_done), .adc_data(adc_data),
		.overtemp(overtemp), .adc_start(adc_start), .mux_sel(mux_sel),
		.test_source_en(test_source_en), .test_inject(test_inject),
		.discharge_sw(discharge_sw), .compare_active(compare_active));
	monitor_controller u_monitor_controller (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .link(lk));
	cell_link_sva u_cell_link_sva (.pclk(pclk), .presetn(presetn),
		.cmd_valid(lk.cmd_valid), .cmd_ready(lk.cmd_ready),
		.cmd_code(lk.cmd_code), .cmd_cell(lk.cmd_cell),
		.cmd_data(lk.cmd_data), .busy(lk.busy), .rsp_valid(lk.rsp_valid),
		.rsp_last(lk.rsp_last), .rsp_data(lk.rsp_data));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic check(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : check
	task automatic hang();
		check(1'b0, "wait ran out");
		end_sim();
	endtask : hang
	// Cell five rises strongly under test current, so input four reads open.
	function automatic logic [11:0] adc_val(input logic [3:0] m, input logic s);
		adc_val = 12'h100 + {4'h0, m, 4'h0};
		if (s)
			adc_val = adc_val + (m == 4'h4 ? 12'h100 : 12'h001);
	endfunction : adc_val
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 20)
			hang();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_cmp(input logic v);
		int k;
		for (k = 0; k < 1100 && compare_active !== v; k++)
			@(posedge pclk);
		if (k == 1100)
			hang();
	endtask : wait_cmp
	// Commands start right after a comparison round so none is refused.
	task automatic do_cmd(input logic [31:0] w);
		int k;
		if (duty_on) begin
			wait_cmp(1'b1);
			wait_cmp(1'b0);
		end
		nst = 0;
		apb(1'b1, REG_CTRL, w);
		repeat (4) @(posedge pclk);
		for (k = 0; k < 3000; k++) begin
			apb(1'b0, REG_STATUS, 32'h0);
			if (rd[1:0] === 2'h0)
				break;
		end
		if (k == 3000)
			hang();
	endtask : do_cmd
	// The sequencer only sees the word once the write command carries it.
	task automatic set_cfg(input logic ten, input logic [2:0] du);
		apb(1'b1, REG_CFG, {16'h0, ten, du, en});
		do_cmd(32'h1);
		duty_on = du != 3'h0;
	endtask : set_cfg
	always @(posedge pclk) begin
		if (adc_start === 1'b1) begin
			adc_done <= 1'b0;
			wt <= 3;
			gm = (13'h0007 << mux_sel) >> 1;
			if (chk && nst > 0) check(mux_sel === lastm + 4'h1, "order");
			if (chk) check(test_source_en === esrc, "test source");
			if (chk) check(test_inject === einj, "inject");
			if (gate == 2'h1) check(discharge_sw === (en & ~gm[11:0]), "gate");
			if (gate == 2'h2) check(discharge_sw === en, "kept on");
			lastm = mux_sel;
			nst = nst + 1;
		end else if (wt > 0) begin
			wt <= wt - 1;
			if (wt == 1) begin
				adc_data <= adc_val(mux_sel, test_source_en);
				adc_done <= 1'b1;
			end
		end
		if (presetn && compare_active === 1'b1)
			check(discharge_sw === 12'h0, "compare switches");
	end
	initial begin
		{presetn, psel, penable, pwrite, adc_done, overtemp, esrc} = 7'h0;
		{paddr, pwdata, adc_data, en, lastm, einj, gate} = '0;
		{chk, duty_on, nst, wt, n_fail, total_checks} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_OW_REPEAT, 32'h0);
		check(rd[3:0] === OW_REPEAT_RESET, "repeat reset");
		apb(1'b0, 12'h100, 32'h0);
		check(er === 1'b1, "unmapped address");
		en = 12'h0ff;
		set_cfg(1'b0, 3'h1);
		chk = 1'b1;
		for (i = 0; i < 4; i++) begin
			gate = i < 2 ? 2'h1 : 2'h2;
			esrc = i[0];
			do_cmd(32'h2 + i);
			check(nst == 12, "cell count");
			do_cmd(32'hb);
			for (j = 0; j < 12; j++) begin
				apb(1'b0, 12'(REG_READING + 4 * j), 32'h0);
				check(rd[11:0] === adc_val(4'(j), esrc), "reading");
			end
		end
		check(discharge_sw === (compare_active ? 12'h0 : en), "idle");
		{gate, esrc} = {2'h1, 1'b0};
		set_cfg(1'b1, 3'h1);
		do_cmd(32'h2);
		check(nst == 10, "ten cells");
		do_cmd(32'hb);
		apb(1'b0, REG_STATUS, 32'h0);
		check(rd[3] === 1'b0, "read count");
		set_cfg(1'b0, 3'h1);
		do_cmd(32'h52);
		check(nst == 1 && lastm === 4'h4, "single cell");
		gate = 2'h0;
		for (i = 7; i <= 10; i++) begin
			einj = i[0] ? 2'h1 : 2'h2;
			do_cmd(32'(i));
			check(nst == (i < 9 ? 12 : 3), "self test length");
			do_cmd(i < 9 ? 32'hb : 32'hc);
			apb(1'b0, 12'(REG_READING + (i < 9 ? 0 : 48)), 32'h0);
			check(rd[11:0] === (i[0] ? SELF1_PATTERN : SELF2_PATTERN), "pattern");
		end
		einj = 2'h0;
		do_cmd(32'h6);
		check(nst == 3, "temperature conversion");
		{chk, einj} = 3'h0;
		apb(1'b1, REG_OW_REPEAT, 32'h3);
		do_cmd(32'h100);
		apb(1'b0, REG_OPEN, 32'h0);
		check(rd[10:0] === 11'h008, "open mask");
		set_cfg(1'b0, 3'h0);
		do_cmd(32'h2);
		check(nst == 0, "standby conversion");
		set_cfg(1'b0, 3'h1);
		overtemp <= 1'b1;
		repeat (8) @(posedge pclk);
		check(discharge_sw === 12'h0 && lk.cmd_ready === 1'b0, "shutdown");
		overtemp <= 1'b0;
		duty_on = 1'b0;
		repeat (4) @(posedge pclk);
		for (i = 1; i >= 0; i--) begin
			do_cmd(32'hc);
			apb(1'b0, REG_STATUS, 32'h0);
			check(rd[2] === i[0], "thermal flag");
		end
		check(discharge_sw === 12'h0, "config reset");
		end_sim();
	end
endmodule : cell_measure_discharge_control_test
`default_nettype wire
